// [hdl/jdpt_defines.vh]
// Constants shared by the debug and trace port files.
// Assumes a single 100 MHz core clock and a four-bit instruction register.
`ifndef JDPT_DEFINES_VH
`define JDPT_DEFINES_VH

`define JDPT_CLK_PERIOD_NS     10
`define JDPT_TRACE_DIV         2'h3
`define JDPT_TRACE_PHASE_LAST  2'h2
`define JDPT_TRACE_PHASE_FIRST 2'h0

`define JDPT_IR_WIDTH          4
`define JDPT_DR_WIDTH          32
`define JDPT_IR_CAPTURE        4'h1
`define JDPT_INSTR_IDCODE      4'h1
`define JDPT_INSTR_TRACE_CTRL  4'h8
`define JDPT_INSTR_BYPASS      4'hF

`define JDPT_TRACE_WIDTH       4
`define JDPT_STATUS_WIDTH      9
`define JDPT_UPPER_RESET       3'h7
`define JDPT_STATUS_RESET      9'h000
`define JDPT_BIT0_RESET        1'h1
`define JDPT_STATUS_IDLE       9'h000

`define JDPT_SYNC_RESET        4'h6

`define JDPT_ST_RESET          4'h0
`define JDPT_ST_IDLE           4'h1
`define JDPT_ST_SEL_DR         4'h2
`define JDPT_ST_CAP_DR         4'h3
`define JDPT_ST_SHIFT_DR       4'h4
`define JDPT_ST_EXIT1_DR       4'h5
`define JDPT_ST_PAUSE_DR       4'h6
`define JDPT_ST_EXIT2_DR       4'h7
`define JDPT_ST_UPD_DR         4'h8
`define JDPT_ST_SEL_IR         4'h9
`define JDPT_ST_CAP_IR         4'hA
`define JDPT_ST_SHIFT_IR       4'hB
`define JDPT_ST_EXIT1_IR       4'hC
`define JDPT_ST_PAUSE_IR       4'hD
`define JDPT_ST_EXIT2_IR       4'hE
`define JDPT_ST_UPD_IR         4'hF

`endif

// [hdl/jdpt_pin_sync.v]
// Two-stage synchroniser for pins that arrive from outside the clock domain.
// Assumes the pins are slow static levels or a test clock far below clk.
`timescale 1ns/1ps
module jdpt_pin_sync
#(
  parameter             WIDTH       = 4,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
)
(
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] pinSync
);

  reg [WIDTH-1:0] pinMeta;

  // The first stage feeds only the second stage.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pinMeta <= RESET_VALUE;
      pinSync <= RESET_VALUE;
    end
    else
    begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

endmodule // jdpt_pin_sync

// [hdl/jdpt_skid_buffer.v]
// Two-entry buffer with valid and ready on both sides.
// Assumes source and sink share clk; flush drops any held words.
`timescale 1ns/1ps
module jdpt_skid_buffer
#(
  parameter WIDTH = 13
)
(
  input  wire             clk,
  input  wire             reset,
  input  wire             flush,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] slot0;
  reg [WIDTH-1:0] slot1;
  reg             wrPtr;
  reg             rdPtr;
  reg [1:0]       count;
  wire            push;
  wire            pop;

  assign inReady  = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData  = rdPtr ? slot1 : slot0;
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      slot0 <= {WIDTH{1'b0}};
      slot1 <= {WIDTH{1'b0}};
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end
    else if (flush)
    begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push & ~wrPtr)
        slot0 <= inData;
      if (push & wrPtr)
        slot1 <= inData;
      if (push)
        wrPtr <= ~wrPtr;
      if (pop)
        rdPtr <= ~rdPtr;
      if (push & ~pop)
        count <= count + 2'h1;
      else if (pop & ~push)
        count <= count - 2'h1;
    end
  end

endmodule // jdpt_skid_buffer

// [hdl/jdpt_debug_port.v]
// Test access port with a program-counter trace output on shared pins.
// Assumes clk is the core clock; test pins are asynchronous and synchronised here.
//
// Notes on behaviour
// - The test clock advances the test access port and paces its serial shifting.
// - Outside trace mode the data-in pin is the serial input of the selected register.
// - In trace mode a low data-in pin is a debug break that ends trace mode.
// - Outside trace mode the data-out pin carries the serial output of the selected register.
// - In trace mode the data-out pin is trace bit 0 and three more pins carry trace bits 3 to 1.
// - The mode-select pin, sampled on the test clock, steers the controller state machine.
// - The test reset pin resets the controller and the debug support unit without a clock.
// - Bus timeout detection is disabled while the test reset pin is deasserted.
// - The trace clock output is the core clock divided by three.
// - In trace mode upper trace bits and the status bus update in step with the trace clock output.
// - A nine-bit status bus reports trace status to the analyzer.
// - After reset data-out is high, upper trace bits high, trace clock low, status low.
`timescale 1ns/1ps
`include "jdpt_defines.vh"
module jdpt_debug_port
#(
  parameter [31:0] ID_VALUE = 32'h00000001
)
(
  input  wire                          clk,
  input  wire                          reset,
  input  wire                          testClock,
  input  wire                          testModeSelect,
  input  wire                          debugBreakInN,
  input  wire                          testResetN,
  output reg                           pcTraceBit0,
  output reg  [2:0]                    pcTraceUpperBits,
  output reg                           traceClockOut,
  output reg  [`JDPT_STATUS_WIDTH-1:0] traceStatusBus,
  input  wire                          traceInValid,
  output wire                          traceInReady,
  input  wire [`JDPT_TRACE_WIDTH-1:0]  traceInData,
  input  wire [`JDPT_STATUS_WIDTH-1:0] traceInStatus,
  input  wire                          traceModeEnter,
  output reg                           traceModeActive,
  output reg                           debugBreak,
  output reg                           busTimeoutDisable
);

  // The identification value is arbitrary.
  localparam BUF_WIDTH = `JDPT_TRACE_WIDTH + `JDPT_STATUS_WIDTH;

  wire                          tapReset;
  wire [3:0]                    syncPins;
  wire                          syncTck;
  wire                          syncTms;
  wire                          syncTdi;
  wire                          syncTrstN;
  wire                          tckRise;
  wire                          tckFall;
  wire                          tdiBit;
  wire                          bufInReady;
  wire                          bufOutValid;
  wire                          bufOutReady;
  wire [BUF_WIDTH-1:0]          bufOutData;
  wire                          traceEdge;
  wire                          breakSeen;
  reg                           tckLast;
  reg  [3:0]                    tapState;
  reg  [`JDPT_IR_WIDTH-1:0]     irShift;
  reg  [`JDPT_IR_WIDTH-1:0]     irReg;
  reg  [`JDPT_DR_WIDTH-1:0]     drShift;
  reg                           tdoReg;
  reg                           traceRequest;
  reg  [1:0]                    tracePhase;
  reg  [1:0]                    next_tracePhase;

  function [3:0] tapNext;
    input [3:0] state;
    input       tms;
    begin
      case (state)
        `JDPT_ST_RESET:    tapNext = tms ? `JDPT_ST_RESET    : `JDPT_ST_IDLE;
        `JDPT_ST_IDLE:     tapNext = tms ? `JDPT_ST_SEL_DR   : `JDPT_ST_IDLE;
        `JDPT_ST_SEL_DR:   tapNext = tms ? `JDPT_ST_SEL_IR   : `JDPT_ST_CAP_DR;
        `JDPT_ST_CAP_DR:   tapNext = tms ? `JDPT_ST_EXIT1_DR : `JDPT_ST_SHIFT_DR;
        `JDPT_ST_SHIFT_DR: tapNext = tms ? `JDPT_ST_EXIT1_DR : `JDPT_ST_SHIFT_DR;
        `JDPT_ST_EXIT1_DR: tapNext = tms ? `JDPT_ST_UPD_DR   : `JDPT_ST_PAUSE_DR;
        `JDPT_ST_PAUSE_DR: tapNext = tms ? `JDPT_ST_EXIT2_DR : `JDPT_ST_PAUSE_DR;
        `JDPT_ST_EXIT2_DR: tapNext = tms ? `JDPT_ST_UPD_DR   : `JDPT_ST_SHIFT_DR;
        `JDPT_ST_UPD_DR:   tapNext = tms ? `JDPT_ST_SEL_DR   : `JDPT_ST_IDLE;
        `JDPT_ST_SEL_IR:   tapNext = tms ? `JDPT_ST_RESET    : `JDPT_ST_CAP_IR;
        `JDPT_ST_CAP_IR:   tapNext = tms ? `JDPT_ST_EXIT1_IR : `JDPT_ST_SHIFT_IR;
        `JDPT_ST_SHIFT_IR: tapNext = tms ? `JDPT_ST_EXIT1_IR : `JDPT_ST_SHIFT_IR;
        `JDPT_ST_EXIT1_IR: tapNext = tms ? `JDPT_ST_UPD_IR   : `JDPT_ST_PAUSE_IR;
        `JDPT_ST_PAUSE_IR: tapNext = tms ? `JDPT_ST_EXIT2_IR : `JDPT_ST_PAUSE_IR;
        `JDPT_ST_EXIT2_IR: tapNext = tms ? `JDPT_ST_UPD_IR   : `JDPT_ST_SHIFT_IR;
        `JDPT_ST_UPD_IR:   tapNext = tms ? `JDPT_ST_SEL_DR   : `JDPT_ST_IDLE;
        default:           tapNext = `JDPT_ST_RESET;
      endcase
    end
  endfunction

  assign tapReset = reset | ~testResetN;

  jdpt_pin_sync
  #(
    .WIDTH       (4),
    .RESET_VALUE (`JDPT_SYNC_RESET)
  )
  pinSyncInst
  (
    .clk     (clk),
    .reset   (reset),
    .pinIn   ({testClock, testModeSelect, debugBreakInN, testResetN}),
    .pinSync (syncPins)
  );

  assign syncTck   = syncPins[3];
  assign syncTms   = syncPins[2];
  assign syncTdi   = syncPins[1];
  assign syncTrstN = syncPins[0];

  assign tckRise = syncTck & ~tckLast;
  assign tckFall = ~syncTck & tckLast;

  // data-in feeds shifts only outside trace mode.
  assign tdiBit = traceModeActive ? 1'b1 : syncTdi;

  // low data-in is a break in trace mode.
  assign breakSeen = traceModeActive & ~syncTdi;

  always @(posedge clk or posedge reset)
  begin
    if (reset)
      tckLast <= 1'b0;
    else
      tckLast <= syncTck;
  end

  // A slow test clock is assumed: each level must last at least two core cycles to be seen.
  always @(posedge clk or posedge tapReset)
  begin
    if (tapReset)
    begin
      tapState     <= `JDPT_ST_RESET;
      irShift      <= {`JDPT_IR_WIDTH{1'b0}};
      irReg        <= `JDPT_INSTR_IDCODE;
      drShift      <= {`JDPT_DR_WIDTH{1'b0}};
      tdoReg       <= `JDPT_BIT0_RESET;
      traceRequest <= 1'b0;
    end
    else
    begin
      traceRequest <= 1'b0;
      if (tckRise)
      begin
        tapState <= tapNext(tapState, syncTms);
        case (tapState)
          `JDPT_ST_RESET:
            irReg <= `JDPT_INSTR_IDCODE;
          `JDPT_ST_CAP_IR:
            irShift <= `JDPT_IR_CAPTURE;
          `JDPT_ST_SHIFT_IR:
            irShift <= {tdiBit, irShift[`JDPT_IR_WIDTH-1:1]};
          `JDPT_ST_UPD_IR:
            irReg <= irShift;
          `JDPT_ST_CAP_DR:
            if (irReg == `JDPT_INSTR_IDCODE)
              drShift <= ID_VALUE;
            else if (irReg == `JDPT_INSTR_TRACE_CTRL)
              drShift <= {{(`JDPT_DR_WIDTH-1){1'b0}}, traceModeActive};
            else
              drShift <= {`JDPT_DR_WIDTH{1'b0}};
          `JDPT_ST_SHIFT_DR:
            if (irReg == `JDPT_INSTR_IDCODE)
              drShift <= {tdiBit, drShift[`JDPT_DR_WIDTH-1:1]};
            else
              drShift <= {{(`JDPT_DR_WIDTH-1){1'b0}}, tdiBit};
          // trace entry through the control register.
          `JDPT_ST_UPD_DR:
            if (irReg == `JDPT_INSTR_TRACE_CTRL)
              traceRequest <= drShift[0];
          default:
            irShift <= irShift;
        endcase
      end
      // scan output changes on the falling test clock.
      if (tckFall)
      begin
        if (tapState == `JDPT_ST_SHIFT_IR)
          tdoReg <= irShift[0];
        else if (tapState == `JDPT_ST_SHIFT_DR)
          tdoReg <= drShift[0];
        else
          tdoReg <= `JDPT_BIT0_RESET;
      end
    end
  end

  // Break has priority over entry, so a probe holding the pin low cannot be overridden.
  always @(posedge clk or posedge tapReset)
  begin
    if (tapReset)
    begin
      traceModeActive <= 1'b0;
      debugBreak      <= 1'b0;
    end
    else
    begin
      debugBreak <= breakSeen;
      if (breakSeen)
        traceModeActive <= 1'b0;
      // debug support unit or a control register update enters trace mode.
      else if (traceModeEnter | traceRequest)
        traceModeActive <= 1'b1;
    end
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
      busTimeoutDisable <= 1'b0;
    else
      busTimeoutDisable <= syncTrstN;
  end

  always @*
  begin
    if (tracePhase == `JDPT_TRACE_PHASE_LAST)
      next_tracePhase = `JDPT_TRACE_PHASE_FIRST;
    else
      next_tracePhase = tracePhase + 2'h1;
  end

  assign traceEdge = (tracePhase == `JDPT_TRACE_PHASE_LAST);

  always @(posedge clk or posedge tapReset)
  begin
    if (tapReset)
    begin
      tracePhase    <= `JDPT_TRACE_PHASE_FIRST;
      traceClockOut <= 1'b0;
    end
    else
    begin
      tracePhase    <= next_tracePhase;
      traceClockOut <= traceEdge;
    end
  end

  // Words are drained once per trace clock, so the core stalls when it outruns the pins.
  assign bufOutReady  = traceEdge & traceModeActive;
  assign traceInReady = bufInReady & traceModeActive;

  jdpt_skid_buffer
  #(
    .WIDTH (BUF_WIDTH)
  )
  traceBufInst
  (
    .clk      (clk),
    .reset    (tapReset),
    .flush    (~traceModeActive),
    .inValid  (traceInValid & traceModeActive),
    .inReady  (bufInReady),
    .inData   ({traceInStatus, traceInData}),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );

  // reset levels of the trace pins.
  always @(posedge clk or posedge tapReset)
  begin
    if (tapReset)
    begin
      pcTraceBit0      <= `JDPT_BIT0_RESET;
      pcTraceUpperBits <= `JDPT_UPPER_RESET;
      traceStatusBus   <= `JDPT_STATUS_RESET;
    end
    else if (~traceModeActive)
    begin
      pcTraceBit0      <= tdoReg;
      pcTraceUpperBits <= `JDPT_UPPER_RESET;
      traceStatusBus   <= `JDPT_STATUS_RESET;
    end
    // update on the rising trace clock.
    else if (traceEdge)
    begin
      if (bufOutValid)
      begin
        // bit 0 on data-out, bits 3 to 1 upper.
        pcTraceBit0      <= bufOutData[0];
        // upper bits follow the trace clock.
        pcTraceUpperBits <= bufOutData[`JDPT_TRACE_WIDTH-1:1];
        traceStatusBus   <= bufOutData[BUF_WIDTH-1:`JDPT_TRACE_WIDTH];
      end
      else
        traceStatusBus <= `JDPT_STATUS_IDLE;
    end
  end

endmodule // jdpt_debug_port

// [sim/jdpt_debug_port_props.sv]
// Concurrent checks on the debug and trace port.
// Assumes it is bound to jdpt_debug_port and sees only its ports.
`timescale 1ns/1ps
module jdpt_debug_port_props
(
  input wire       clk,
  input wire       reset,
  input wire       testClock,
  input wire       testModeSelect,
  input wire       debugBreakInN,
  input wire       testResetN,
  input wire       pcTraceBit0,
  input wire [2:0] pcTraceUpperBits,
  input wire       traceClockOut,
  input wire [8:0] traceStatusBus,
  input wire       traceInValid,
  input wire       traceInReady,
  input wire [3:0] traceInData,
  input wire [8:0] traceInStatus,
  input wire       traceModeEnter,
  input wire       traceModeActive,
  input wire       debugBreak,
  input wire       busTimeoutDisable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  AST_DIV3:
    assert property (disable iff (reset || !testResetN)
      traceClockOut |=> !traceClockOut ##1 !traceClockOut ##1 traceClockOut) else $error("trace clock not clk/3");
  AST_RESET:
    assert property (disable iff (1'h0) reset ##1 reset |-> pcTraceBit0 && pcTraceUpperBits == 3'h7 && !traceClockOut
      && traceStatusBus == 9'h000) else $error("bad reset pin values");
  AST_IDLE:
    assert property (!traceModeActive && $past(!traceModeActive) |-> pcTraceUpperBits == 3'h7
      && traceStatusBus == 9'h000) else $error("trace pins active outside trace mode");
  // Changes right after entry are the pin mux switching over, so they are left out.
  AST_EDGE:
    assert property (traceModeActive && $past(traceModeActive) && $past(traceModeActive, 2)
      && ($changed(pcTraceUpperBits) || $changed(traceStatusBus)) |-> $rose(traceClockOut))
      else $error("trace pins moved off the trace clock edge");
  AST_BREAK:
    assert property ($rose(debugBreak) |-> $fell(traceModeActive)) else $error("break kept trace mode");
  AST_TIMEOUT:
    assert property (testResetN [*5] |-> busTimeoutDisable) else $error("timeout not disabled");
  AST_TRSTN:
    assert property (!testResetN |-> !traceModeActive && pcTraceUpperBits == 3'h7 && traceStatusBus == 9'h000
      && !traceInReady) else $error("test reset did not clear trace logic");
  AST_READY:
    assert property (traceInReady |-> traceModeActive) else $error("ready outside trace mode");
  // The buffer is flushed while trace mode is off, so entry always finds room.
  AST_FRESH:
    assert property ($rose(traceModeActive) |-> traceInReady) else $error("buffer not empty on trace entry");
  COV_WORD: cover property (traceModeActive && $rose(traceClockOut) && traceStatusBus != 9'h000);
  COV_FULL: cover property (traceModeActive && traceInValid && !traceInReady);
  COV_BREAK: cover property (debugBreak);
endmodule // jdpt_debug_port_props

bind jdpt_debug_port jdpt_debug_port_props u_props
(
  .clk(clk), .reset(reset), .testClock(testClock), .testModeSelect(testModeSelect),
  .debugBreakInN(debugBreakInN), .testResetN(testResetN), .pcTraceBit0(pcTraceBit0),
  .pcTraceUpperBits(pcTraceUpperBits), .traceClockOut(traceClockOut), .traceStatusBus(traceStatusBus),
  .traceInValid(traceInValid), .traceInReady(traceInReady), .traceInData(traceInData),
  .traceInStatus(traceInStatus), .traceModeEnter(traceModeEnter), .traceModeActive(traceModeActive),
  .debugBreak(debugBreak), .busTimeoutDisable(busTimeoutDisable)
);

// [sim/jdpt_probe_model.sv]
// Behavioural debug probe that drives the test pins of the port.
// Assumes clk is the core clock; test clock high phases last six core cycles, low phases twelve.
`timescale 1ns/1ps
module jdpt_probe_model
(
  input  wire  clk,
  input  wire  testDataOut,
  output logic testClock,
  output logic testModeSelect,
  output logic debugBreakInN,
  output logic testResetN
);
  initial
  begin
    testClock = 1'h0;
    testModeSelect = 1'h1;
    debugBreakInN = 1'h1;
    testResetN = 1'h1;
  end
  task automatic tick(input logic tms, input logic tdi);
    testModeSelect = tms;
    debugBreakInN = tdi;
    repeat (6) @(negedge clk);
    testClock = 1'h1;
    repeat (6) @(negedge clk);
    testClock = 1'h0;
    repeat (6) @(negedge clk);
  endtask
  task automatic tap_reset;
    repeat (5) tick(1'h1, 1'h1);
    tick(1'h0, 1'h1);
  endtask
  // The pulled-up data line is left high once a scan ends.
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = 32'h0;
    tick(1'h1, 1'h1);
    if (ir)
      tick(1'h1, 1'h1);
    tick(1'h0, 1'h1);
    tick(1'h0, 1'h1);
    for (int i = 0; i < n; i++)
    begin
      dout[i] = testDataOut;
      tick(i == n - 1, din[i]);
    end
    tick(1'h1, 1'h1);
    tick(1'h0, 1'h1);
  endtask
  task automatic set_break(input logic v);
    debugBreakInN = v;
  endtask
  task automatic set_trst(input logic v);
    testResetN = v;
  endtask
endmodule // jdpt_probe_model

// [sim/test_jdpt_debug_port.sv]
// Self-checking bench for the debug and trace port.
// Assumes the probe model drives the test pins and the checker is bound in.
`timescale 1ns/1ps
module test_jdpt_debug_port;
  // Identification value is arbitrary.
  localparam logic [31:0] ID = 32'h5A3C0E91;
  logic clk, reset, traceInValid, traceModeEnter;
  logic [3:0] traceInData;
  logic [8:0] traceInStatus;
  wire tck, tms, tdi, trstN, pcTraceBit0, traceClockOut, traceInReady, traceModeActive, debugBreak, busTimeoutDisable;
  wire [2:0] pcTraceUpperBits;
  wire [8:0] traceStatusBus;
  int fails, num_checks;
  logic [12:0] got[$];
  logic [31:0] d;
  jdpt_debug_port #(.ID_VALUE(ID)) uut
  (
    .clk(clk), .reset(reset), .testClock(tck), .testModeSelect(tms), .debugBreakInN(tdi),
    .testResetN(trstN), .pcTraceBit0(pcTraceBit0), .pcTraceUpperBits(pcTraceUpperBits),
    .traceClockOut(traceClockOut), .traceStatusBus(traceStatusBus), .traceInValid(traceInValid),
    .traceInReady(traceInReady), .traceInData(traceInData), .traceInStatus(traceInStatus),
    .traceModeEnter(traceModeEnter), .traceModeActive(traceModeActive), .debugBreak(debugBreak),
    .busTimeoutDisable(busTimeoutDisable)
  );
  jdpt_probe_model probe
  (
    .clk(clk), .testDataOut(pcTraceBit0), .testClock(tck), .testModeSelect(tms),
    .debugBreakInN(tdi), .testResetN(trstN)
  );
  always #5 clk = ~clk;
  // Words are taken while the trace clock is high, when the pins have settled.
  always @(negedge clk)
    if (traceClockOut === 1'h1 && traceModeActive === 1'h1 && traceStatusBus !== 9'h000)
      got.push_back({traceStatusBus, pcTraceUpperBits, pcTraceBit0});
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic t_reset;
    repeat (4) @(negedge clk);
    check("dataOut", pcTraceBit0, 32'h1);
    check("upper", pcTraceUpperBits, 32'h7);
    check("traceClk", traceClockOut, 32'h0);
    check("status", traceStatusBus, 32'h0);
    reset = 1'h0;
    repeat (5) @(negedge clk);
    check("toDisable", busTimeoutDisable, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_scan;
    probe.tap_reset();
    probe.scan(1'h0, 32, 32'h0, d);
    check("idcode", d, ID);
    probe.scan(1'h1, 4, 32'hF, d);
    check("irCapture", d, 32'h1);
    probe.scan(1'h0, 8, 32'hB4, d);
    check("bypass", d, 32'h68);
    $display("scan test done");
  endtask
  // Words are offered every cycle, faster than the trace clock drains them.
  task automatic t_trace;
    logic full;
    full = 1'h0;
    traceModeEnter = 1'h1;
    @(negedge clk);
    traceModeEnter = 1'h0;
    got.delete();
    for (int i = 1; i <= 6; i++)
    begin
      traceInValid = 1'h1;
      traceInData = 4'(i);
      traceInStatus = 9'h100 | 9'(i);
      // Ready is judged at the falling edge, where it has settled after the push edge.
      while (traceInReady !== 1'h1)
      begin
        full = 1'h1;
        @(negedge clk);
      end
      @(negedge clk);
    end
    traceInValid = 1'h0;
    repeat (30) @(negedge clk);
    check("full", full, 32'h1);
    check("count", got.size(), 32'h6);
    foreach (got[j])
      check("word", got[j], 13'h1000 | 13'((j + 1) * 17));
    $display("trace test done");
  endtask
  task automatic t_break;
    probe.set_break(1'h0);
    for (int n = 0; n < 20 && debugBreak !== 1'h1; n++)
      @(negedge clk);
    check("break", debugBreak, 32'h1);
    check("mode", traceModeActive, 32'h0);
    @(negedge clk);
    check("upper", pcTraceUpperBits, 32'h7);
    check("ready", traceInReady, 32'h0);
    probe.set_break(1'h1);
    repeat (4) @(negedge clk);
    probe.scan(1'h1, 4, 32'h8, d);
    probe.scan(1'h0, 1, 32'h1, d);
    check("ctrlCapture", d, 32'h0);
    check("mode", traceModeActive, 32'h1);
    $display("break test done");
  endtask
  task automatic t_trst;
    probe.set_trst(1'h0);
    #2;
    check("mode", traceModeActive, 32'h0);
    repeat (5) @(negedge clk);
    check("toDisable", busTimeoutDisable, 32'h0);
    probe.set_trst(1'h1);
    repeat (5) @(negedge clk);
    check("toDisable", busTimeoutDisable, 32'h1);
    $display("test reset test done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    fails++;
    results();
  end
  initial
  begin
    clk = 1'h0;
    reset = 1'h1;
    traceInValid = 1'h0;
    traceModeEnter = 1'h0;
    traceInData = 4'h0;
    traceInStatus = 9'h000;
    t_reset();
    t_scan();
    t_trace();
    t_break();
    t_trst();
    results();
  end
endmodule // test_jdpt_debug_port
